// file: shared/sfdp_table_pkg.sv
// Package: constants of the discovery parameter table block
package sfdp_table_pkg;
	localparam int          ADDR_W        = 16;              // Byte address width into the discovery space
	localparam logic [15:0] TABLE_BASE    = 16'h1120;        // Location of basic parameter data
	localparam logic [15:0] HDR_BASE      = 16'h111e;        // Two header bytes precede the data
	localparam int          TABLE_LEN     = 18;              // Header plus dwords one to four
	localparam logic [7:0]  FILL_BYTE     = 8'hff;           // Answer outside the table
	localparam logic [15:0] ADDR_RST      = 16'h0000;        // Reader address after reset
	localparam logic [15:0] ADDR_STEP     = 16'h0001;        // Address increment per byte
	localparam logic [7:0]  BLOCK_ID      = 8'ha5;           // Parameter block identifier
	localparam logic [7:0]  BLOCK_LEN     = 8'h80;           // Bytes following the length byte
	localparam logic [2:0]  UNUSED3       = 3'h7;            // Unused bits read as ones
	localparam logic        UNUSED1       = 1'h1;            // Unused single bit reads as one
	localparam logic [7:0]  UNUSED8       = 8'hff;           // Unused byte reads as ones
	localparam logic [1:0]  SR_WR_NV06    = 2'h0;            // Status reg non-volatile, write via 06h
	localparam logic        PGM_BUF_BIG   = 1'h1;            // Program buffer above 64 bytes
	localparam logic [1:0]  ERASE4K_NONE  = 2'h3;            // Uniform 4 KB erase unavailable
	localparam logic [7:0]  ERASE4K_OP    = 8'hff;           // No 4 KB erase opcode
	localparam logic        SUP_QOUT      = 1'h1;            // Quad output read supported
	localparam logic        SUP_QIO       = 1'h1;            // Quad I/O read supported
	localparam logic        SUP_DIO       = 1'h1;            // Dual I/O read supported
	localparam logic        SUP_DDR       = 1'h0;            // Double data rate not supported
	localparam logic [1:0]  ADDR_BYTES    = 2'h1;            // Three or four address bytes
	localparam logic        SUP_DOUT      = 1'h1;            // Dual output read supported
	localparam logic [31:0] DENSITY       = 32'h07ffffff;    // Array bits, zero based
	localparam logic [2:0]  QIO_MODE      = 3'h2;            // Quad I/O mode cycles
	localparam logic [4:0]  QIO_DUMMY     = 5'h04;           // Quad I/O dummy cycles
	localparam logic [7:0]  QIO_OP        = 8'heb;           // Quad I/O read opcode
	localparam logic [2:0]  QOUT_MODE     = 3'h0;            // Quad out mode cycles
	localparam logic [4:0]  QOUT_DUMMY    = 5'h08;           // Quad out dummy cycles
	localparam logic [7:0]  QOUT_OP       = 8'h6b;           // Quad out read opcode
	localparam logic [2:0]  DOUT_MODE     = 3'h0;            // Dual out mode cycles
	localparam logic [4:0]  DOUT_DUMMY    = 5'h08;           // Dual out dummy cycles
	localparam logic [7:0]  DOUT_OP       = 8'h3b;           // Dual out read opcode
	localparam logic [7:0]  DIO_MODE_DUMMY= 8'h80;           // Dual I/O four mode, no dummy
	localparam logic [7:0]  DIO_OP        = 8'hbb;           // Dual I/O read opcode
endpackage

// file: design/sfdp_table.sv
// Read-only discovery parameter table with streaming byte reader
`timescale 1ns/1ns
// How it works
// (RULE_01) First byte is identifier A5h
// (RULE_02) Second byte is following count 80h
// (RULE_03) Basic parameter data starts at 1120h
// (RULE_04) Report 4 KB erase unavailable, opcode FFh
// (RULE_05) Status register non-volatile, written by 06h
// (RULE_06) Bit 2 marks program buffer above 64
// (RULE_07) Quad and dual read kinds all supported
// (RULE_08) Double data rate bit reads zero
// (RULE_09) Address bytes field reads 01b
// (RULE_10) Density dword reads 07FFFFFFh
// (RULE_11) Quad I/O: EBh, two mode, four dummy
// (RULE_12) Quad out: 6Bh, no mode, eight dummy
// (RULE_13) Dual out: 3Bh, no mode, eight dummy
// (RULE_14) Dual I/O: BBh, mode/dummy byte 80h
// (RULE_15) Read-only, bytes returned in ascending order
//
// A read starts at start_i with addr_i; each next_i steps one byte up.
// Bytes outside the table answer as fill.
// The table is a fixed image: nothing the host sends can alter it.
// start_i wins over next_i, so a host may restart in any cycle.
// Outputs are registered: a request shows one clock later and then stands
// until the next start or step.
// Back to back requests in every cycle are fine; nothing is refused.
// The address wraps from the top of the space back to zero.
// Limitation: only the header and the first four dwords are mapped;
// the rest of the block the count byte promises reads as fill.
// Reset only parks the reader at address zero; the image has no state.
// A host that walks past the last mapped byte sees hit_o drop.
// The serial framing lives elsewhere; this is the byte source behind it.
module sfdp_table
#(
	parameter int ADDR_W = sfdp_table_pkg::ADDR_W  // Byte address width into the space
)
(
	input  wire logic              mclk_i,   // System clock, 10 MHz
	input  wire logic              rstn_i,   // Synchronous reset, active low
	input  wire logic              start_i,  // Load start address, pulse
	input  wire logic [ADDR_W-1:0] addr_i,   // Start byte address
	input  wire logic              next_i,   // Advance to next byte, pulse
	output logic      [7:0]        data_o,   // Byte at current address
	output logic      [ADDR_W-1:0] addr_o,   // Current byte address
	output logic                   hit_o     // Address lies in the table
);
	// Byte map, offset from the header start:
	//  0      block identifier
	//  1      count of bytes that follow
	//  2      erase, status register and buffer fields
	//  3      4 KB erase opcode
	//  4      read capability bits and address bytes
	//  5      top byte of dword one, unused ones
	//  6..9   density in bits, zero based, low byte first
	//  10,11  quad I/O mode/dummy byte, then its opcode
	//  12,13  quad out mode/dummy byte, then its opcode
	//  14,15  dual out mode/dummy byte, then its opcode
	//  16,17  dual I/O mode/dummy byte, then its opcode
	// Anything past offset 17 is not mapped and reads as fill.
	localparam int ROM_IDX_W = $clog2(sfdp_table_pkg::TABLE_LEN); // Index bits into the image

	// Table contents as a constant byte array
	// Fields pack most significant first within each byte
	logic [7:0] rom [sfdp_table_pkg::TABLE_LEN];
	assign rom[0]  = sfdp_table_pkg::BLOCK_ID;                                  // [RULE_01]
	assign rom[1]  = sfdp_table_pkg::BLOCK_LEN;                                 // [RULE_02]
	assign rom[2]  = {sfdp_table_pkg::UNUSED3, sfdp_table_pkg::SR_WR_NV06,      // [RULE_05]
	                  sfdp_table_pkg::PGM_BUF_BIG, sfdp_table_pkg::ERASE4K_NONE}; // [RULE_06] [RULE_04]
	assign rom[3]  = sfdp_table_pkg::ERASE4K_OP;                                // [RULE_04]
	assign rom[4]  = {sfdp_table_pkg::UNUSED1, sfdp_table_pkg::SUP_QOUT, sfdp_table_pkg::SUP_QIO, // [RULE_07]
	                  sfdp_table_pkg::SUP_DIO, sfdp_table_pkg::SUP_DDR,         // [RULE_08]
	                  sfdp_table_pkg::ADDR_BYTES, sfdp_table_pkg::SUP_DOUT};    // [RULE_09]
	assign rom[5]  = sfdp_table_pkg::UNUSED8;                                   // Unused top byte
	assign rom[6]  = sfdp_table_pkg::DENSITY[7:0];                              // [RULE_10]
	assign rom[7]  = sfdp_table_pkg::DENSITY[15:8];                             // [RULE_10]
	assign rom[8]  = sfdp_table_pkg::DENSITY[23:16];                            // [RULE_10]
	assign rom[9]  = sfdp_table_pkg::DENSITY[31:24];                            // [RULE_10]
	assign rom[10] = {sfdp_table_pkg::QIO_MODE, sfdp_table_pkg::QIO_DUMMY};     // [RULE_11]
	assign rom[11] = sfdp_table_pkg::QIO_OP;                                    // [RULE_11]
	assign rom[12] = {sfdp_table_pkg::QOUT_MODE, sfdp_table_pkg::QOUT_DUMMY};   // [RULE_12]
	assign rom[13] = sfdp_table_pkg::QOUT_OP;                                   // [RULE_12]
	assign rom[14] = {sfdp_table_pkg::DOUT_MODE, sfdp_table_pkg::DOUT_DUMMY};   // [RULE_13]
	assign rom[15] = sfdp_table_pkg::DOUT_OP;                                   // [RULE_13]
	assign rom[16] = sfdp_table_pkg::DIO_MODE_DUMMY;                            // [RULE_14]
	assign rom[17] = sfdp_table_pkg::DIO_OP;                                    // [RULE_14]

	// Reader state
	logic [ADDR_W-1:0] addr_q, addr_d;  // Current read address
	logic [7:0]        data_q, data_d;  // Registered output byte
	logic              hit_q,  hit_d;   // Registered in-table flag
	logic [ADDR_W-1:0] idx;             // Offset from block start
	logic [ADDR_W-1:0] nxt;             // Address being loaded

	// Next address, byte lookup; the lookup uses the next address so that
	// the byte and its address leave their flip-flops in the same cycle
	always_comb
	begin
		// Hold by default
		addr_d = addr_q;
		if (start_i)
		begin
			// New start address; beats a step in the same cycle
			addr_d = addr_i;
		end
		else if (next_i)
		begin
			// One byte up, wrapping at the top of the space
			addr_d = addr_q + ADDR_W'(sfdp_table_pkg::ADDR_STEP); // [RULE_15]
		end
		// Lookup follows the address being loaded
		nxt    = addr_d;
		idx    = nxt - ADDR_W'(sfdp_table_pkg::HDR_BASE);         // [RULE_03]
		// Below the header the subtraction wraps high, so the upper bound alone already rejects it
		hit_d  = (nxt >= ADDR_W'(sfdp_table_pkg::HDR_BASE)) &&
		         (idx < ADDR_W'(sfdp_table_pkg::TABLE_LEN));
		// Out of range offsets never reach the array index
		data_d = hit_d ? rom[idx[ROM_IDX_W-1:0]] : sfdp_table_pkg::FILL_BYTE;
	end

	// Registers only
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			// Park the reader at address zero, outside the table
			addr_q <= ADDR_W'(sfdp_table_pkg::ADDR_RST);
			data_q <= sfdp_table_pkg::FILL_BYTE;
			hit_q  <= 1'b0;
		end
		else
		begin
			// Take the next values every clock
			addr_q <= addr_d;
			data_q <= data_d;
			hit_q  <= hit_d;
		end
	end

	// Outputs come straight from the flip-flops
	assign data_o = data_q;
	assign addr_o = addr_q;
	assign hit_o  = hit_q;

	// Checks on what leaves the flip-flops; each table byte check except a_id_first (which uses HDR_BASE) names an absolute address,
	// so a wrong base shows up as a run of failures rather than one.
	// Sampled values: an output checked at an edge is the byte from the
	// request of the edge before.
	// Header bytes ahead of the data
	a_id_first: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_01]
		hit_o && addr_o == sfdp_table_pkg::HDR_BASE |-> data_o == 8'ha5) else $error("id byte wrong");
	a_hdr_hit: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_01]
		addr_o == 16'h111e |-> hit_o && data_o == 8'ha5) else $error("header byte missing");
	a_len_second: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_02]
		hit_o && addr_o == 16'h111f |-> data_o == 8'h80) else $error("length byte wrong");
	// First dword: erase, status register and program buffer fields
	a_base_byte: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_03]
		addr_o == 16'h1120 |-> hit_o && data_o == 8'he7) else $error("first data byte wrong");
	a_erase_field: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_04]
		addr_o == 16'h1120 |-> data_o[1:0] == 2'h3) else $error("erase field wrong");
	a_erase_op: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_04]
		addr_o == 16'h1121 |-> data_o == 8'hff) else $error("erase opcode wrong");
	a_sr_field: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_05]
		addr_o == 16'h1120 |-> data_o[4:3] == 2'h0) else $error("status field wrong");
	a_buf_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_06]
		addr_o == 16'h1120 |-> data_o[2] == 1'b1) else $error("buffer bit wrong");
	// Capability byte of the first dword
	a_caps_byte: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_07]
		addr_o == 16'h1122 |-> data_o == 8'hf3) else $error("capability byte wrong");
	a_read_kinds: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_07]
		addr_o == 16'h1122 |-> data_o[6:4] == 3'h7 && data_o[0] == 1'b1) else $error("read kind bits wrong");
	a_ddr_bit: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_08]
		addr_o == 16'h1122 |-> data_o[3] == 1'b0) else $error("ddr bit wrong");
	a_addr_field: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_09]
		addr_o == 16'h1122 |-> data_o[2:1] == 2'h1) else $error("address field wrong");
	// Density dword, low byte first
	a_density_low: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_10]
		addr_o >= 16'h1124 && addr_o <= 16'h1126 |-> data_o == 8'hff) else $error("density low wrong");
	a_density_top: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_10]
		addr_o == 16'h1127 |-> data_o == 8'h07) else $error("density top wrong");
	// Quad I/O pair; the opcode check also looks one byte back on a step
	a_qio_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_11]
		addr_o == 16'h1128 |-> data_o == 8'h44) else $error("quad io cycles wrong");
	a_qio_op: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_11]
		addr_o == 16'h1129 && $past(next_i) && !$past(start_i) |-> data_o == 8'heb && $past(data_o) == 8'h44)
		else $error("quad io fields wrong");
	// Quad out and dual out pairs
	a_qout_fields: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_12]
		addr_o == 16'h112a |-> data_o == 8'h08) else $error("quad out cycles wrong");
	a_qout_op: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_12]
		addr_o == 16'h112b |-> data_o == 8'h6b) else $error("quad out opcode wrong");
	a_dout_fields: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_13]
		addr_o == 16'h112c |-> data_o == 8'h08) else $error("dual out cycles wrong");
	a_dout_op: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_13]
		addr_o == 16'h112d |-> data_o == 8'h3b) else $error("dual out opcode wrong");
	// Dual I/O pair, last mapped bytes
	a_dio_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_14]
		addr_o == 16'h112e |-> data_o == 8'h80) else $error("dual io cycles wrong");
	a_dio_op: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_14]
		addr_o == 16'h112f |-> data_o == 8'hbb) else $error("dual io opcode wrong");
	// Address movement: load, step, hold
	a_start_load: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_15]
		start_i |=> addr_o == $past(addr_i)) else $error("start address not loaded");
	a_step_up: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_15]
		next_i && !start_i |=> addr_o == $past(addr_o) + 16'h0001) else $error("address not stepped");
	a_hold_addr: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_15]
		!next_i && !start_i |=> $stable(addr_o) && $stable(data_o)) else $error("idle byte changed");
	// Edges of the mapped window and the fill answer
	a_below_miss: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_03]
		addr_o == 16'h111d |-> !hit_o && data_o == 8'hff) else $error("byte below table wrong");
	a_tail_miss: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_03]
		addr_o == 16'h1130 |-> !hit_o && data_o == 8'hff) else $error("byte past table wrong");
	a_hit_range: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_03]
		hit_o |-> addr_o >= 16'h111e && addr_o <= 16'h112f) else $error("hit outside table");
	a_outside_fill: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [RULE_03]
		!hit_o |-> data_o == 8'hff) else $error("fill byte wrong");
	// Reset parks the reader outside the table
	a_reset_idle: assert property (@(posedge mclk_i) // [RULE_15]
		!rstn_i |=> addr_o == 16'h0000 && data_o == 8'hff && !hit_o) else $error("reset state wrong");
	// Main scenarios: a start at the header, a walk, running off the end,
	// a start and a step together, and a wrap at the top of the space
	c_start_hdr: cover property (@(posedge mclk_i) start_i && addr_i == sfdp_table_pkg::HDR_BASE);
	c_walk_two: cover property (@(posedge mclk_i) hit_o ##1 next_i ##1 hit_o);
	c_run_off: cover property (@(posedge mclk_i) hit_o ##1 !hit_o);
	c_start_next: cover property (@(posedge mclk_i) start_i && next_i);
	c_wrap_top: cover property (@(posedge mclk_i) addr_o == 16'hffff && next_i && !start_i);
endmodule // sfdp_table

// file: verif/host_reader.sv
// Host-side reader model that requests table bytes and finds the next block
`timescale 1ns/1ns
module host_reader
(
	input  wire logic        go_i,     // Load a start address
	input  wire logic        step_i,   // Ask for the following byte
	input  wire logic [15:0] base_i,   // Requested start address
	input  wire logic [15:0] pos_i,    // Address of the length byte
	input  wire logic [7:0]  len_i,    // Length byte just read
	output logic             start_o,  // Start request to the table
	output logic             next_o,   // Step request to the table
	output logic      [15:0] addr_o,   // Start address to the table
	output logic      [15:0] blk_o     // Address of the next block
);
	// Requests pass straight through; the bench times them
	assign start_o = go_i;
	assign next_o  = step_i;
	assign addr_o  = base_i;
	// Next block lies past the length byte plus its count
	assign blk_o   = pos_i + {8'h00, len_i} + 16'h0001;
endmodule // host_reader

// file: verif/tb.sv
// Self-checking bench for the discovery parameter table
`timescale 1ns/1ns
module tb;
	logic        mclk_i, rstn_i, go, step, start_w, next_w, hit_o; // Clock, reset, requests
	logic [15:0] base, addr_w, blk_w, addr_o;                      // Addresses
	logic [7:0]  data_o;                                           // Table byte
	int          num_errors, checks, i;                            // Counters
	// Rows: {hit, address, byte} for one ascending sweep
	logic [24:0] rows [20] = '{25'h0_111d_ff, 25'h1_111e_a5, 25'h1_111f_80,
		25'h1_1120_e7, 25'h1_1121_ff, 25'h1_1122_f3, 25'h1_1123_ff,
		25'h1_1124_ff, 25'h1_1125_ff, 25'h1_1126_ff, 25'h1_1127_07,
		25'h1_1128_44, 25'h1_1129_eb, 25'h1_112a_08, 25'h1_112b_6b,
		25'h1_112c_08, 25'h1_112d_3b, 25'h1_112e_80, 25'h1_112f_bb, 25'h0_1130_ff};
	host_reader i_host_reader (.go_i(go), .step_i(step), .base_i(base), .pos_i(addr_o), .len_i(data_o),
		.start_o(start_w), .next_o(next_w), .addr_o(addr_w), .blk_o(blk_w));
	sfdp_table i_sfdp_table (.mclk_i(mclk_i), .rstn_i(rstn_i), .start_i(start_w), .addr_i(addr_w),
		.next_i(next_w), .data_o(data_o), .addr_o(addr_o), .hit_o(hit_o));
	// Clock, 100 ns period
	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	// Compare outputs against an expected row
	task cmp(input logic [24:0] e);
		checks++;
		if ({hit_o, addr_o, data_o} !== e)
		begin
			num_errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, {hit_o, addr_o, data_o}, e);
		end
	endtask
	// One request on a falling edge, checked after the next rising edge
	task rd(input logic s, input logic n, input logic [15:0] a, input logic [24:0] e);
		@(negedge mclk_i);
		go = s; step = n; base = a;
		@(posedge mclk_i);
		#1 cmp(e);
	endtask
	// Drop all requests
	task idle;
		@(negedge mclk_i);
		go = 1'b0; step = 1'b0;
	endtask
	// Counts and verdict
	task print_verdict;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		#200000 num_errors++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		go = 1'b0; step = 1'b0; base = 16'h0000; rstn_i = 1'b0; num_errors = 0; checks = 0;
		repeat (16) @(negedge mclk_i);
		cmp(25'h0_0000_ff);
		rstn_i = 1'b1;
		for (i = 0; i < 20; i++) rd(i == 0, i != 0, 16'h111d, rows[i]);
		$display("sweep done");
		rd(1'b1, 1'b1, 16'h112f, 25'h1_112f_bb);
		rd(1'b1, 1'b0, 16'h111f, 25'h1_111f_80);
		rd(1'b1, 1'b0, blk_w, 25'h0_11a0_ff);
		rd(1'b1, 1'b0, 16'hffff, 25'h0_ffff_ff);
		rd(1'b0, 1'b1, 16'h0000, 25'h0_0000_ff);
		rd(1'b1, 1'b0, 16'h1120, 25'h1_1120_e7);
		idle();
		repeat (2) @(negedge mclk_i);
		cmp(25'h1_1120_e7);
		rstn_i = 1'b0;
		@(negedge mclk_i);
		rstn_i = 1'b1;
		cmp(25'h0_0000_ff);
		rd(1'b1, 1'b0, 16'h111e, 25'h1_111e_a5);
		rd(1'b0, 1'b1, 16'h0000, 25'h1_111f_80);
		$display("edge cases done");
		print_verdict();
	end
endmodule // tb
